// >>> include/interval_timer_pkg.sv
package interval_timer_pkg;

  // Counter and register port widths
  localparam int COUNT_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_INTERVAL = 8'h0C;

  // Status and mask bit positions, reset values
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_START = 1;
  localparam int STAT_W = 2;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Time base
  localparam int CRYSTAL_HZ = 32768;
  localparam int CLK_MHZ = 100;

  // Interrupt pulse widths in microseconds and in system clock cycles
  localparam int T_PULSE_SHORT_US = 7800;
  localparam int T_PULSE_LONG_US = 125000;
  localparam int PULSE_SHORT_CYC = T_PULSE_SHORT_US * CLK_MHZ;
  localparam int PULSE_LONG_CYC = T_PULSE_LONG_US * CLK_MHZ;

  // Restart bounce filter: level must stand this long to be accepted
  localparam int T_DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC = T_DEBOUNCE_US * CLK_MHZ;

  // Interval per captured select pair {lo, hi}, in seconds
  localparam logic [23:0] IVL_SEL00_S = 24'h00_003C;
  localparam logic [23:0] IVL_SEL01_S = 24'h00_000A;
  localparam logic [23:0] IVL_SEL10_S = 24'h00_001E;
  localparam logic [23:0] IVL_SEL11_S = 24'h00_0001;

  typedef enum logic [1:0] {
    MODE_LOOP = 2'b00,
    MODE_HANDSHAKE = 2'b01,
    MODE_TOGGLE = 2'b10
  } timeout_mode_t;

  typedef enum logic [1:0] {
    ST_HELD = 2'b00,
    ST_RUN = 2'b01,
    ST_PULSE = 2'b10,
    ST_LATCHED = 2'b11
  } tmr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : interval_timer_pkg

// >>> hw/restart_filter.sv
`timescale 1ns/1ps
module restart_filter #(
  parameter int unsigned STABLE_CYCLES = interval_timer_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Raw and filtered restart level
  input wire logic raw_in,
  output logic filt_out
);
  import interval_timer_pkg::*;

  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  logic filt_ff;
  logic nxt_filt;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  // A new level must stand unbroken before it is passed on
  always_comb begin
    nxt_filt = filt_ff;
    nxt_cnt = '0;
    if (raw_in != filt_ff) begin
      if (cnt_ff == LAST) begin
        nxt_filt = raw_in;
      end else begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      filt_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      filt_ff <= nxt_filt;
      cnt_ff <= nxt_cnt;
    end
  end

  assign filt_out = filt_ff;

  a_filter_stable_level: assert property ( // [R8]
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(filt_ff) |-> ($past(cnt_ff) == LAST) && ($past(raw_in) == filt_ff))
    else $error("restart filter passed a level that did not stand");

endmodule : restart_filter

// >>> hw/second_prescaler.sv
`timescale 1ns/1ps
module second_prescaler #(
  parameter int unsigned DIV = interval_timer_pkg::CRYSTAL_HZ
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Crystal oscillator
  input wire logic crystal_in,
  output logic crystal_out,
  // Control and tick
  input wire logic clear_in,
  output logic sec_tick_out
);
  import interval_timer_pkg::*;

  localparam int DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);

  logic xtal_prev_ff;
  logic crystal_out_ff;
  logic tick_ff;
  logic nxt_tick;
  logic [DW-1:0] div_ff;
  logic [DW-1:0] nxt_div;
  logic xtal_rise;

  assign xtal_rise = crystal_in & ~xtal_prev_ff;

  // [R14] one-second divider
  always_comb begin
    nxt_div = div_ff;
    nxt_tick = 1'b0;
    if (clear_in) begin
      nxt_div = '0;
    end else if (xtal_rise) begin
      if (div_ff == LAST) begin
        nxt_div = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_div = div_ff + DW'(1);
      end
    end
  end

  // [R11] inverting oscillator stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xtal_prev_ff <= 1'b0;
      crystal_out_ff <= 1'b1;
      tick_ff <= 1'b0;
      div_ff <= '0;
    end else begin
      xtal_prev_ff <= crystal_in;
      crystal_out_ff <= ~crystal_in;
      tick_ff <= nxt_tick;
      div_ff <= nxt_div;
    end
  end

  assign crystal_out = crystal_out_ff;
  assign sec_tick_out = tick_ff;

  a_tick_after_div: assert property ( // [R14]
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    tick_ff |-> $past(div_ff) == LAST && $past(xtal_rise) && div_ff == '0)
    else $error("second tick without a full crystal divide");

endmodule : second_prescaler

// >>> hw/interval_timer.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// [R1] 24-bit seconds counter only counts upward
// [R2] Interrupt when count reaches selected interval
// [R3] Selects captured on restart rising edge
// [R4] Select changes ignored while running
// [R5] Selects map to 60,10,30,1 seconds
// [R6] Restart low clears and stops timer
// [R7] Restart release: interrupt high, count from zero
// [R8] Restart input filtered against contact bounce
// [R9] Loop interrupt is fixed-width low pulse
// [R10] Signalling style fixed: loop, handshake, toggle
// [R11] Time base from crystal-rate oscillator
// [R12] Whole-second intervals up to about half-year; the selects here give 60 seconds at most
// [R13] Loop pulse repeats every interval until restart
// [R14] Crystal divided by 32768 gives second tick
module interval_timer #(
  parameter int unsigned PULSE_CYCLES = interval_timer_pkg::PULSE_SHORT_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = interval_timer_pkg::DEBOUNCE_CYC,
  parameter int unsigned PRESCALE_DIV = interval_timer_pkg::CRYSTAL_HZ,
  parameter interval_timer_pkg::timeout_mode_t TIMEOUT_MODE = interval_timer_pkg::MODE_LOOP
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Host pins
  input wire logic restart_n_in,
  input wire logic interval_select_lo_in,
  input wire logic interval_select_hi_in,
  output logic int_n_out,
  // Crystal
  input wire logic crystal_in,
  output logic crystal_out,
  // Register port
  input wire interval_timer_pkg::reg_req_t reg_req_in,
  output logic [interval_timer_pkg::DATA_W-1:0] reg_rdata_out,
  output logic irq_out
);
  import interval_timer_pkg::*;

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

  tmr_state_t state_ff;
  tmr_state_t nxt_state;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic [COUNT_W-1:0] interval_ff;
  logic [COUNT_W-1:0] nxt_interval;
  logic [COUNT_W-1:0] count_inc;
  logic [1:0] sel_ff;
  logic [1:0] nxt_sel;
  logic [PW-1:0] pulse_ff;
  logic [PW-1:0] nxt_pulse;
  logic int_n_ff;
  logic nxt_int_n;
  logic restart_filt;
  logic restart_prev_ff;
  logic restart_rise;
  logic sec_tick;
  logic counting;
  logic fire;

  logic [STAT_W-1:0] status_ff;
  logic [STAT_W-1:0] nxt_status;
  logic [STAT_W-1:0] mask_ff;
  logic [STAT_W-1:0] nxt_mask;
  logic [STAT_W-1:0] events;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // [R8] bounce filter on restart
  restart_filter #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_filter (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .raw_in(restart_n_in),
    .filt_out(restart_filt)
  );

  // [R11] crystal time base, held cleared while restart holds the timer in ST_HELD
  second_prescaler #(
    .DIV(PRESCALE_DIV)
  ) u_prescaler (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .crystal_in(crystal_in),
    .crystal_out(crystal_out),
    .clear_in(state_ff == ST_HELD),
    .sec_tick_out(sec_tick)
  );

  // [R5] select pair to interval
  function automatic logic [COUNT_W-1:0] interval_of(input logic [1:0] sel);
    logic [COUNT_W-1:0] ivl;
    unique case (sel)
      2'b00: ivl = IVL_SEL00_S;
      2'b01: ivl = IVL_SEL01_S;
      2'b10: ivl = IVL_SEL10_S;
      2'b11: ivl = IVL_SEL11_S;
    endcase
    return ivl;
  endfunction : interval_of

  assign restart_rise = restart_filt & ~restart_prev_ff;
  assign counting = (state_ff == ST_RUN) || (state_ff == ST_PULSE);
  // [R12] whole seconds, 24 bits span half a year
  assign count_inc = count_ff + 24'h00_0001;
  // [R2] match against captured interval
  assign fire = counting && sec_tick && restart_filt && (count_inc == interval_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_sel = sel_ff;
    nxt_interval = interval_ff;
    nxt_int_n = int_n_ff;
    nxt_pulse = pulse_ff;
    if (!restart_filt) begin
      // [R6] held restart clears the timer
      nxt_state = ST_HELD;
      nxt_count = '0;
      nxt_pulse = '0;
      nxt_int_n = 1'b1;
    end else if (restart_rise) begin
      // [R3] capture selects on release
      nxt_sel = {interval_select_lo_in, interval_select_hi_in};
      nxt_interval = interval_of({interval_select_lo_in, interval_select_hi_in});
      // [R7] start clean with interrupt inactive
      nxt_count = '0;
      nxt_pulse = '0;
      nxt_int_n = 1'b1;
      nxt_state = ST_RUN;
    end else begin
      // [R1] upward count, wrapping at the match
      if (counting && sec_tick) begin
        nxt_count = fire ? '0 : count_inc;
      end
      unique case (state_ff)
        ST_HELD: begin
          nxt_state = ST_HELD;
        end
        ST_RUN: begin
          if (fire) begin
            // [R10] style fixed by build parameter
            unique case (TIMEOUT_MODE)
              MODE_LOOP: begin
                nxt_state = ST_PULSE;
                nxt_pulse = '0;
                nxt_int_n = 1'b0;
              end
              MODE_HANDSHAKE: begin
                nxt_state = ST_LATCHED;
                nxt_int_n = 1'b0;
              end
              MODE_TOGGLE: begin
                nxt_int_n = ~int_n_ff;
              end
              default: begin
                nxt_state = ST_RUN;
              end
            endcase
          end
        end
        ST_PULSE: begin
          // [R9] fixed-width low pulse while the count runs on, then back to ST_RUN
          if (pulse_ff == PULSE_LAST) begin
            // [R13] back to ST_RUN, so it repeats
            nxt_state = ST_RUN;
            nxt_int_n = 1'b1;
            nxt_pulse = '0;
          end else begin
            nxt_pulse = pulse_ff + PW'(1);
          end
        end
        ST_LATCHED: begin
          // Held low until the host restarts; counting stops meanwhile
          nxt_int_n = 1'b0;
        end
      endcase
    end
  end

  // [R4] selects only move on the release edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_HELD;
      count_ff <= '0;
      sel_ff <= 2'b00;
      interval_ff <= IVL_SEL00_S;
      pulse_ff <= '0;
      int_n_ff <= 1'b1;
      restart_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      sel_ff <= nxt_sel;
      interval_ff <= nxt_interval;
      pulse_ff <= nxt_pulse;
      int_n_ff <= nxt_int_n;
      restart_prev_ff <= restart_filt;
    end
  end

  assign int_n_out = int_n_ff;

  // Register port: status is write-one-to-clear, and a new event beats its clear
  assign events = {restart_rise, fire};

  always_comb begin
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    nxt_rdata = '0;
    if (reg_req_in.wr && reg_req_in.addr == ADDR_STATUS) begin
      nxt_status = status_ff & ~reg_req_in.wdata[STAT_W-1:0];
    end
    if (reg_req_in.wr && reg_req_in.addr == ADDR_MASK) begin
      nxt_mask = reg_req_in.wdata[STAT_W-1:0];
    end
    nxt_status = nxt_status | events;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        ADDR_STATUS: nxt_rdata = {{(DATA_W-STAT_W){1'b0}}, status_ff};
        ADDR_MASK: nxt_rdata = {{(DATA_W-STAT_W){1'b0}}, mask_ff};
        ADDR_COUNT: nxt_rdata = {{(DATA_W-COUNT_W){1'b0}}, count_ff};
        ADDR_INTERVAL: nxt_rdata = {{(DATA_W-COUNT_W){1'b0}}, interval_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_ff <= STATUS_RST;
      mask_ff <= MASK_RST;
      rdata_ff <= '0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign irq_out = |(status_ff & mask_ff);

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_release;
    restart_filt && !restart_prev_ff;
  endsequence

  sequence s_match_tick;
    (state_ff == ST_RUN) && restart_filt && !restart_rise && sec_tick && count_inc == interval_ff;
  endsequence

  a_count_held_zero: assert property ( // [R6]
    !restart_filt |=> count_ff == '0 && state_ff == ST_HELD && int_n_out)
    else $error("timer not cleared while restart held low");

  a_capture_on_release: assert property ( // [R3]
    s_release |=> sel_ff == $past({interval_select_lo_in, interval_select_hi_in}))
    else $error("selects not captured on restart release");

  a_select_frozen_run: assert property ( // [R4]
    !restart_rise |=> $stable(sel_ff) && $stable(interval_ff))
    else $error("interval changed while running");

  a_interval_table: assert property ( // [R5]
    state_ff != ST_HELD |-> interval_ff == interval_of(sel_ff))
    else $error("interval does not match captured selects");

  a_start_clean: assert property ( // [R7]
    s_release |=> int_n_out && count_ff == '0 && state_ff == ST_RUN)
    else $error("restart release did not start from zero");

  a_count_upward: assert property ( // [R1]
    counting && restart_filt && !restart_rise && sec_tick && !fire
      |=> count_ff == $past(count_inc))
    else $error("counter did not advance by one second");

  a_count_still: assert property ( // [R14]
    !sec_tick && restart_filt && !restart_rise |=> $stable(count_ff))
    else $error("counter moved without a second tick");

  a_match_fires: assert property ( // [R2]
    s_match_tick |=> count_ff == '0 && status_ff[STAT_TIMEOUT])
    else $error("match did not raise the timeout");

  a_loop_pulse_start: assert property ( // [R13]
    (s_match_tick and (TIMEOUT_MODE == MODE_LOOP)) |=> !int_n_out ##0 state_ff == ST_PULSE)
    else $error("loop interrupt pulse did not start at match");

  a_pulse_width_end: assert property ( // [R9]
    state_ff == ST_PULSE && restart_filt && pulse_ff == PULSE_LAST |=> int_n_out)
    else $error("loop pulse did not end at its width");

  a_pulse_low_hold: assert property ( // [R9]
    state_ff == ST_PULSE && restart_filt && pulse_ff != PULSE_LAST
      |=> !int_n_out && pulse_ff == $past(pulse_ff) + PW'(1))
    else $error("loop pulse ended early");

  a_status_sticky: assert property ( // [R2]
    status_ff[STAT_TIMEOUT] && !(reg_req_in.wr && reg_req_in.addr == ADDR_STATUS)
      |=> status_ff[STAT_TIMEOUT])
    else $error("status bit lost without a clear");

endmodule : interval_timer

// >>> dv/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned DEB = 4
) (
  // Clock
  input wire logic clk_sys_in,
  // Pins toward the timer
  output logic restart_n_out,
  output logic sel_lo_out,
  output logic sel_hi_out,
  output logic xtal_out
);
  logic ph_ff;

  initial begin
    restart_n_out = 1'b0;
    sel_lo_out = 1'b0;
    sel_hi_out = 1'b0;
    xtal_out = 1'b0;
    ph_ff = 1'b0;
  end

  // Free running crystal, one period per four system clocks
  always @(posedge clk_sys_in) begin
    ph_ff <= ~ph_ff;
    if (ph_ff) begin
      xtal_out <= ~xtal_out;
    end
  end

  task automatic restart(input logic [1:0] sel);
    restart_n_out <= 1'b0;
    repeat (DEB + 2) @(posedge clk_sys_in);
    {sel_lo_out, sel_hi_out} <= sel;
    restart_n_out <= 1'b1;
    repeat (DEB + 4) @(posedge clk_sys_in);
    // Scramble the pins once latched, a real host is free to
    {sel_lo_out, sel_hi_out} <= ~sel;
  endtask : restart

  // Contact bounce shorter than the filter span
  task automatic glitch();
    restart_n_out <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    restart_n_out <= 1'b1;
  endtask : glitch

  task automatic hold_low();
    restart_n_out <= 1'b0;
  endtask : hold_low
endmodule : host_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  import interval_timer_pkg::*;
  localparam int unsigned DEB = 4;
  localparam int unsigned PULSE = 5;
  localparam int unsigned DIV = 4;
  // One second is DIV crystal periods of four system clocks
  localparam int unsigned SEC_CYC = DIV * 4;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic restart_n, sel_lo, sel_hi, xtal, xtal_back, int_n, irq;
  logic int_n_hs, int_n_tg, xb;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v0, v1;
  int mismatches = 0;
  int samples_checked = 0;
  int n, m;

  always #5 clk_sys_in = ~clk_sys_in;

  host_model #(.DEB(DEB)) i_host_model (
    .clk_sys_in(clk_sys_in),
    .restart_n_out(restart_n),
    .sel_lo_out(sel_lo),
    .sel_hi_out(sel_hi),
    .xtal_out(xtal)
  );

  interval_timer #(
    .PULSE_CYCLES(PULSE),
    .DEBOUNCE_CYCLES(DEB),
    .PRESCALE_DIV(DIV),
    .TIMEOUT_MODE(MODE_LOOP)
  ) i_interval_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .restart_n_in(restart_n),
    .interval_select_lo_in(sel_lo),
    .interval_select_hi_in(sel_hi),
    .int_n_out(int_n),
    .crystal_in(xtal),
    .crystal_out(xtal_back),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .irq_out(irq)
  );

  // Handshake and toggle builds share every input with the loop build
  interval_timer #(
    .PULSE_CYCLES(PULSE),
    .DEBOUNCE_CYCLES(DEB),
    .PRESCALE_DIV(DIV),
    .TIMEOUT_MODE(MODE_HANDSHAKE)
  ) i_interval_timer_hs (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .restart_n_in(restart_n),
    .interval_select_lo_in(sel_lo),
    .interval_select_hi_in(sel_hi),
    .int_n_out(int_n_hs),
    .crystal_in(xtal),
    .crystal_out(),
    .reg_req_in(req),
    .reg_rdata_out(),
    .irq_out()
  );

  interval_timer #(
    .PULSE_CYCLES(PULSE),
    .DEBOUNCE_CYCLES(DEB),
    .PRESCALE_DIV(DIV),
    .TIMEOUT_MODE(MODE_TOGGLE)
  ) i_interval_timer_tg (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .restart_n_in(restart_n),
    .interval_select_lo_in(sel_lo),
    .interval_select_hi_in(sel_hi),
    .int_n_out(int_n_tg),
    .crystal_in(xtal),
    .crystal_out(),
    .reg_req_in(req),
    .reg_rdata_out(),
    .irq_out()
  );

  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    req <= '0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    req <= '0;
    #1;
    d = rdata;
  endtask : reg_read

  // Bounded wait for the interrupt pin, counted in whole cycles
  task automatic wait_int(input logic val, output int cnt);
    cnt = 0;
    while (int_n !== val && cnt < SEC_CYC * 64) begin
      @(negedge clk_sys_in);
      cnt++;
    end
    if (int_n !== val) begin
      mismatches++;
      $display("[FAIL] %0t interrupt pin never reached %b", $time, val);
    end
  endtask : wait_int

  function automatic logic [31:0] ivl_of(input logic [1:0] sel);
    case (sel)
      2'b00: return 32'h0000_003C;
      2'b01: return 32'h0000_000A;
      2'b10: return 32'h0000_001E;
      default: return 32'h0000_0001;
    endcase
  endfunction : ivl_of

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    reg_read(ADDR_STATUS, v0);
    check(v0, 32'h0000_0000);
    reg_read(ADDR_MASK, v0);
    check(v0, 32'h0000_0000);
    reg_read(8'hFC, v0);
    check(v0, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    reg_read(ADDR_INTERVAL, v0);
    check(v0, ivl_of(2'b00));
    // Read data stand one cycle only
    @(posedge clk_sys_in);
    #1;
    check(rdata, 32'h0000_0000);
    // crystal stage returns the inverse one cycle late
    repeat (4) begin
      @(posedge clk_sys_in);
      xb = ~xtal;
      #1;
      check({31'h0, xtal_back}, {31'h0, xb});
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys_in);
      i_host_model.restart(s[1:0]);
      #1;
      check({30'h0, int_n_hs, int_n}, 32'h0000_0003);
      reg_read(ADDR_INTERVAL, v0);
      check(v0, ivl_of(s[1:0]));
      reg_read(ADDR_STATUS, v0);
      check(v0 & 32'h0000_0002, 32'h0000_0002);
      if (s != 3) begin
        // count rises by two or three ticks over 34 cycles
        reg_read(ADDR_COUNT, v0);
        repeat (2 * SEC_CYC) @(posedge clk_sys_in);
        reg_read(ADDR_COUNT, v1);
        check({31'h0, (v1 - v0 == 2) || (v1 - v0 == 3)}, 32'h0000_0001);
      end
      wait_int(1'b0, n);
      check({30'h0, int_n_hs, int_n_tg}, 32'h0000_0000);
      wait_int(1'b1, n);
      check(32'(n), 32'(PULSE));
      wait_int(1'b0, m);
      check({30'h0, int_n_hs, int_n_tg}, 32'h0000_0001);
      check(32'(n + m), ivl_of(s[1:0]) * SEC_CYC);
    end
    // Unmasked timeout drives the level interrupt, clear drops it
    reg_write(ADDR_MASK, 32'h0000_0001);
    // Old timeout cleared only after the unmask, so it raises the level briefly before the next one
    reg_write(ADDR_STATUS, 32'h0000_0001);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    wait_int(1'b1, n);
    wait_int(1'b0, n);
    check({31'h0, irq}, 32'h0000_0001);
    reg_write(ADDR_STATUS, 32'h0000_0001);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    reg_write(ADDR_MASK, 32'h0000_0000);
    wait_int(1'b1, n);
    wait_int(1'b0, n);
    check({31'h0, irq}, 32'h0000_0000);
    reg_read(ADDR_STATUS, v0);
    check(v0, 32'h0000_0003);
    // a short bounce must not restart the timer
    reg_write(ADDR_STATUS, 32'h0000_0003);
    i_host_model.glitch();
    repeat (DEB + 4) @(posedge clk_sys_in);
    reg_read(ADDR_STATUS, v0);
    check(v0 & 32'h0000_0002, 32'h0000_0000);
    // held restart keeps the count cleared across seconds
    @(posedge clk_sys_in);
    i_host_model.hold_low();
    repeat (DEB + 4) @(posedge clk_sys_in);
    reg_read(ADDR_COUNT, v0);
    check(v0, 32'h0000_0000);
    repeat (3 * SEC_CYC) @(posedge clk_sys_in);
    reg_read(ADDR_COUNT, v0);
    check(v0, 32'h0000_0000);
    check({31'h0, int_n}, 32'h0000_0001);
    check({30'h0, int_n_hs, int_n_tg}, 32'h0000_0003);
    report_and_stop();
  end
endmodule : tb
